// ===== inc/vhm_consts.svh
`ifndef VHM_CONSTS_SVH
`define VHM_CONSTS_SVH
// ****************************************
// register offsets
// ****************************************
`define VHM_OFS_ENC_SEL 16'h1412
`define VHM_OFS_MEAS_SPD 16'h1e10
`define VHM_OFS_GEN_SPD 16'h1f0c
`define VHM_OFS_TGT_VEL 16'h2402
`define VHM_OFS_ACCEL 16'h3000
`define VHM_OFS_DECEL 16'h3002
`define VHM_OFS_CEIL 16'h3004
`define VHM_OFS_HM_METHOD 16'h3006
`define VHM_OFS_HM_DIST 16'h3008
`define VHM_OFS_HM_OFFSET 16'h300a
`define VHM_OFS_SET_POS 16'h300c
`define VHM_OFS_ACT_POS 16'h300e
// ****************************************
// reset values and limits
// ****************************************
`define VHM_ENC_SEL_RST 16'h0000
`define VHM_ENC_UNDEF 16'h0000
`define VHM_ENC_POS_ONLY 16'h0002
`define VHM_ENC_ROT_MON 16'h0003
`define VHM_VEL_MAX 32'sd3000
`define VHM_VEL_MIN -32'sd3000
`define VHM_CEIL_RST 32'h00000bb8
`define VHM_ACCEL_RST 32'h00000001
`define VHM_HM_DIST_RST 32'h00000010
// ****************************************
// control word fields
// ****************************************
`define VHM_DC_ENABLE 0
`define VHM_DC_HALT 1
`define VHM_DC_START 2
`define VHM_DC_SETPOS 3
`define VHM_MC_MODE_LO 0
`define VHM_MC_MODE_HI 1
`endif

// ===== inc/vhm_pkg.sv
package vhm_pkg;
  typedef enum logic [1:0] {
    VHM_MODE_IDLE = 2'b00,
    VHM_MODE_VEL = 2'b01,
    VHM_MODE_HOME = 2'b10
  } vhm_mode_e;
  typedef enum logic [2:0] {
    VHM_HS_IDLE = 3'b000,
    VHM_HS_SEEK = 3'b001,
    VHM_HS_TRAVEL = 3'b010,
    VHM_HS_INDEX = 3'b011,
    VHM_HS_DONE = 3'b100,
    VHM_HS_FAIL = 3'b101
  } vhm_hstate_e;
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
  } vhm_reg_req_s;
  typedef struct packed {
    logic neg_limit;
    logic pos_limit;
    logic ref_sw;
    logic index_pulse;
    logic fault;
  } vhm_axis_s;
endpackage : vhm_pkg

// ===== src/vhm_param_mem.sv
`timescale 1ns/10ps
`include "vhm_consts.svh"
// ****************************************
// motion parameter store, registered read
// ****************************************
module vhm_param_mem
  import vhm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [31:0] rd_data,
  output logic [31:0] accel,
  output logic [31:0] decel,
  output logic [31:0] ceil,
  output logic [31:0] hm_dist,
  output logic [31:0] hm_offset
);
  logic [31:0] mem_ff [0:7];
  logic [31:0] nxt_mem [0:7];
  logic [31:0] rd_ff;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_word
      always_comb begin
        nxt_mem[gi] = mem_ff[gi];
        if (wr_en && wr_idx == 3'(gi)) begin
          nxt_mem[gi] = wr_data;
        end
      end
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          mem_ff[gi] <= (gi == 2) ? `VHM_CEIL_RST :
                        (gi == 3) ? `VHM_HM_DIST_RST :
                        (gi < 2) ? `VHM_ACCEL_RST : 32'h0;
        end else begin
          mem_ff[gi] <= nxt_mem[gi];
        end
      end
    end
  endgenerate
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_ff <= 32'h0;
    end else begin
      rd_ff <= nxt_mem[rd_idx];
    end
  end
  assign rd_data = rd_ff;
  assign accel = mem_ff[0];
  assign decel = mem_ff[1];
  assign ceil = mem_ff[2];
  assign hm_dist = mem_ff[3];
  assign hm_offset = mem_ff[4];
endmodule : vhm_param_mem

// ===== src/vhm_ramp.sv
`timescale 1ns/10ps
// ****************************************
// velocity ramp generator
// ****************************************
module vhm_ramp
  import vhm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic signed [31:0] target,
  input wire logic [31:0] accel,
  input wire logic [31:0] decel,
  output logic signed [31:0] speed
);
  logic signed [31:0] speed_ff;
  logic signed [31:0] nxt_speed;
  logic signed [32:0] diff;
  logic signed [32:0] step;
  logic speeding_up;
  always_comb begin
    diff = 33'(target) - 33'(speed_ff);
    // steps with the sign of the target (zero counts as positive) use accel, other steps use decel
    speeding_up = (target >= 0) ? (diff > 0) : (diff < 0);
    step = speeding_up ? $signed({1'b0, accel}) : $signed({1'b0, decel});
    if (diff > step) begin
      nxt_speed = 32'(33'(speed_ff) + step);
    end else if (diff < -step) begin
      nxt_speed = 32'(33'(speed_ff) - step);
    end else begin
      nxt_speed = target;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      speed_ff <= 32'sh0;
    end else begin
      speed_ff <= nxt_speed;
    end
  end
  assign speed = speed_ff;
endmodule : vhm_ramp

// ===== src/vhm_ctrl.sv
`timescale 1ns/10ps
`include "vhm_consts.svh"
module vhm_ctrl
  import vhm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire vhm_reg_req_s reg_req,
  output logic [31:0] reg_rdata,
  input wire logic [15:0] process_word_two,
  input wire logic process_word_two_valid,
  input wire logic [15:0] drive_control_word,
  input wire logic [15:0] mode_control_word,
  output logic [15:0] drive_status_word,
  output logic [15:0] mode_status_word,
  input wire vhm_axis_s axis,
  input wire logic signed [15:0] encoder_speed,
  input wire logic signed [31:0] encoder_position,
  output logic signed [31:0] speed_command,
  output logic encoder_temp_monitor_en,
  output logic rotation_monitor_en
);
  // ****************************************
  // register decode
  // ****************************************
  function automatic logic [3:0] reg_index(input logic [15:0] a);
    case (a)
      `VHM_OFS_ACCEL: reg_index = 4'h0;
      `VHM_OFS_DECEL: reg_index = 4'h1;
      `VHM_OFS_CEIL: reg_index = 4'h2;
      `VHM_OFS_HM_DIST: reg_index = 4'h3;
      `VHM_OFS_HM_OFFSET: reg_index = 4'h4;
      `VHM_OFS_ENC_SEL: reg_index = 4'h8;
      `VHM_OFS_MEAS_SPD: reg_index = 4'h9;
      `VHM_OFS_GEN_SPD: reg_index = 4'ha;
      `VHM_OFS_TGT_VEL: reg_index = 4'hb;
      `VHM_OFS_HM_METHOD: reg_index = 4'hc;
      `VHM_OFS_SET_POS: reg_index = 4'hd;
      `VHM_OFS_ACT_POS: reg_index = 4'he;
      default: reg_index = 4'hf;
    endcase
  endfunction : reg_index

  function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                               input logic signed [31:0] c);
    logic signed [31:0] lim;
    lim = (c < `VHM_VEL_MAX) ? c : `VHM_VEL_MAX;
    if (v > lim) begin
      clamp = lim;
    end else if (v < -lim) begin
      clamp = -lim;
    end else begin
      clamp = v;
    end
  endfunction : clamp

  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic [31:0] mem_rdata;
  logic [31:0] accel;
  logic [31:0] decel;
  logic [31:0] ceil;
  logic [31:0] hm_dist;
  logic [31:0] hm_offset;
  logic signed [31:0] gen_speed;

  assign wr_idx = reg_index(reg_req.addr);
  assign rd_idx = reg_index(reg_req.addr);

  vhm_param_mem u_mem (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wr_en(reg_req.wr && !wr_idx[3]),
    .wr_idx(wr_idx[2:0]),
    .wr_data(reg_req.wdata),
    .rd_idx(rd_idx[2:0]),
    .rd_data(mem_rdata),
    .accel(accel),
    .decel(decel),
    .ceil(ceil),
    .hm_dist(hm_dist),
    .hm_offset(hm_offset)
  );

  // ****************************************
  // mode, target and homing state
  // ****************************************
  vhm_mode_e mode_ff, nxt_mode;
  vhm_hstate_e hs_ff, nxt_hs;
  logic [15:0] enc_sel_ff, nxt_enc_sel;
  logic [1:0] method_ff, nxt_method;
  logic signed [31:0] target_ff, nxt_target;
  logic signed [31:0] setpos_ff, nxt_setpos;
  logic signed [31:0] pos_ff, nxt_pos;
  logic signed [31:0] travel_ff, nxt_travel;
  logic ref_valid_ff, nxt_ref_valid;
  logic rd_sel_ff, nxt_rd_sel;
  logic [31:0] rd_local_ff, nxt_rd_local;
  logic [1:0] req_mode;
  logic enabled;
  logic halt;
  logic start;
  logic encoder_on;
  logic sw_hit;
  logic dir_pos;
  logic signed [31:0] home_speed;
  logic signed [31:0] ramp_target;
  logic signed [31:0] speed_abs;

  assign enabled = drive_control_word[`VHM_DC_ENABLE];
  assign halt = drive_control_word[`VHM_DC_HALT];
  assign start = drive_control_word[`VHM_DC_START];
  assign req_mode = mode_control_word[`VHM_MC_MODE_HI:`VHM_MC_MODE_LO];
  assign encoder_on = (enc_sel_ff == `VHM_ENC_POS_ONLY) ||
                      (enc_sel_ff == `VHM_ENC_ROT_MON);
  // methods: 0 neg limit, 1 pos limit, 2 ref neg, 3 ref pos
  assign dir_pos = method_ff[0];
  assign sw_hit = method_ff[1] ? axis.ref_sw :
                  (method_ff[0] ? axis.pos_limit : axis.neg_limit);
  assign home_speed = dir_pos ? 32'sd60 : -32'sd60;

  always_comb begin
    nxt_enc_sel = enc_sel_ff;
    nxt_method = method_ff;
    nxt_target = target_ff;
    nxt_setpos = setpos_ff;
    if (reg_req.wr) begin
      case (wr_idx)
        4'h8: nxt_enc_sel = reg_req.wdata[15:0];
        4'hb: nxt_target = clamp($signed(reg_req.wdata), $signed(ceil));
        4'hc: nxt_method = reg_req.wdata[1:0];
        4'hd: nxt_setpos = $signed(reg_req.wdata);
        default: nxt_method = method_ff;
      endcase
    end
    if (process_word_two_valid) begin
      nxt_target = clamp(32'($signed(process_word_two)), $signed(ceil));
    end
  end

  always_comb begin
    nxt_mode = mode_ff;
    nxt_hs = hs_ff;
    nxt_travel = travel_ff;
    nxt_ref_valid = ref_valid_ff;
    nxt_pos = pos_ff + 32'(gen_speed >>> 4);
    if (drive_control_word[`VHM_DC_SETPOS] && hs_ff != VHM_HS_SEEK &&
        hs_ff != VHM_HS_TRAVEL && hs_ff != VHM_HS_INDEX) begin
      nxt_pos = setpos_ff;
      nxt_ref_valid = 1'b1;
    end
    if (!enabled && !encoder_on) begin
      nxt_ref_valid = 1'b0;
    end
    case (hs_ff)
      VHM_HS_IDLE, VHM_HS_DONE, VHM_HS_FAIL: begin
        if (!enabled) begin
          nxt_mode = VHM_MODE_IDLE;
        end else if (start && req_mode == 2'h2) begin
          nxt_mode = VHM_MODE_HOME;
          nxt_hs = VHM_HS_SEEK;
          nxt_ref_valid = 1'b0;
        end else if (start && req_mode == 2'h1) begin
          nxt_mode = VHM_MODE_VEL;
          nxt_hs = VHM_HS_IDLE;
        end
      end
      VHM_HS_SEEK: begin
        if (sw_hit) begin
          nxt_travel = 32'sh0;
          nxt_hs = mode_control_word[2] ? VHM_HS_INDEX : VHM_HS_TRAVEL;
        end
      end
      VHM_HS_TRAVEL: begin
        nxt_travel = travel_ff + 32'sh1;
        // the entry cycle counts, so travel lasts exactly hm_dist cycles
        if (travel_ff + 32'sh1 >= $signed(hm_dist)) begin
          nxt_hs = VHM_HS_DONE;
        end
      end
      VHM_HS_INDEX: begin
        if (!encoder_on) begin
          nxt_hs = VHM_HS_FAIL;
        end else if (axis.index_pulse) begin
          nxt_hs = VHM_HS_DONE;
        end
      end
      default: nxt_hs = VHM_HS_IDLE;
    endcase
    if (hs_ff == VHM_HS_SEEK || hs_ff == VHM_HS_TRAVEL || hs_ff == VHM_HS_INDEX) begin
      if (axis.fault || !enabled || (halt && gen_speed == 32'sh0)) begin
        nxt_hs = VHM_HS_FAIL;
        nxt_mode = VHM_MODE_IDLE;
      end else if (nxt_hs == VHM_HS_DONE) begin
        nxt_pos = $signed(hm_offset);
        nxt_ref_valid = 1'b1;
        nxt_mode = VHM_MODE_IDLE;
      end
    end
  end

  always_comb begin
    nxt_rd_sel = !rd_idx[3];
    case (rd_idx)
      4'h8: nxt_rd_local = {16'h0, enc_sel_ff};
      4'h9: nxt_rd_local = {{16{speed_abs[15]}}, speed_abs[15:0]};
      4'ha: nxt_rd_local = gen_speed;
      4'hb: nxt_rd_local = target_ff;
      4'hc: nxt_rd_local = {30'h0, method_ff};
      4'hd: nxt_rd_local = setpos_ff;
      4'he: nxt_rd_local = encoder_on ? encoder_position : pos_ff;
      default: nxt_rd_local = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff <= VHM_MODE_IDLE;
      hs_ff <= VHM_HS_IDLE;
      enc_sel_ff <= `VHM_ENC_SEL_RST;
      method_ff <= 2'h0;
      target_ff <= 32'sh0;
      setpos_ff <= 32'sh0;
      pos_ff <= 32'sh0;
      travel_ff <= 32'sh0;
      ref_valid_ff <= 1'b0;
      rd_sel_ff <= 1'b0;
      rd_local_ff <= 32'h0;
    end else begin
      mode_ff <= nxt_mode;
      hs_ff <= nxt_hs;
      enc_sel_ff <= nxt_enc_sel;
      method_ff <= nxt_method;
      target_ff <= nxt_target;
      setpos_ff <= nxt_setpos;
      pos_ff <= nxt_pos;
      travel_ff <= nxt_travel;
      ref_valid_ff <= nxt_ref_valid;
      rd_sel_ff <= nxt_rd_sel;
      rd_local_ff <= nxt_rd_local;
    end
  end

  // ****************************************
  // ramp and outputs
  // ****************************************
  // no position limit check feeds the velocity path
  assign ramp_target = (mode_ff == VHM_MODE_VEL && !halt) ? target_ff :
                       (mode_ff == VHM_MODE_HOME && !halt &&
                        (hs_ff == VHM_HS_SEEK || hs_ff == VHM_HS_TRAVEL ||
                         hs_ff == VHM_HS_INDEX)) ? home_speed : 32'sh0;

  vhm_ramp u_ramp (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .target(ramp_target),
    .accel(accel),
    .decel(decel),
    .speed(gen_speed)
  );

  assign speed_abs = encoder_on ? 32'(encoder_speed) : gen_speed;
  assign speed_command = gen_speed;
  assign reg_rdata = rd_sel_ff ? mem_rdata : rd_local_ff;
  assign encoder_temp_monitor_en = encoder_on;
  assign rotation_monitor_en = (enc_sel_ff == `VHM_ENC_ROT_MON);
  assign drive_status_word = {13'h0, (hs_ff == VHM_HS_FAIL), ref_valid_ff, enabled};
  assign mode_status_word = {11'h0, hs_ff, mode_ff};

  // ****************************************
  // checks
  // ****************************************
  AST_HOME_BLOCKS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (hs_ff == VHM_HS_SEEK && !axis.fault && enabled && !halt && !sw_hit)
      |=> mode_ff == VHM_MODE_HOME)
    else $error("mode changed during homing");
  AST_REF_AFTER_DONE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(ref_valid_ff) |-> $past(hs_ff) inside {VHM_HS_TRAVEL, VHM_HS_INDEX} ||
      $past(drive_control_word[`VHM_DC_SETPOS]))
    else $error("reference valid without completion");
  AST_FAIL_CLEARS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $past(axis.fault) && $past(hs_ff) == VHM_HS_SEEK |-> hs_ff == VHM_HS_FAIL)
    else $error("fault did not end homing");
  AST_CLAMP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    target_ff <= 32'sd3000 && target_ff >= -32'sd3000)
    else $error("target beyond range");
  AST_PZD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    process_word_two_valid && $signed(process_word_two) <= $signed(ceil) &&
      $signed(process_word_two) >= -$signed(ceil) &&
      $signed(process_word_two) <= 16'sd3000 && $signed(process_word_two) >= -16'sd3000
      |=> target_ff == 32'($signed($past(process_word_two))))
    else $error("process word not taken");
  AST_TEMP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    encoder_temp_monitor_en == (enc_sel_ff inside {16'h0002, 16'h0003}))
    else $error("temperature monitor wrong");
  AST_RAMP_MOVE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode_ff == VHM_MODE_VEL && !halt && target_ff > gen_speed && accel > 0)
      |=> gen_speed > $past(gen_speed))
    else $error("ramp did not advance");
  AST_SETPOS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    drive_control_word[`VHM_DC_SETPOS] &&
      hs_ff inside {VHM_HS_IDLE, VHM_HS_DONE, VHM_HS_FAIL}
      |=> pos_ff == $past(setpos_ff))
    else $error("position setting failed");
  COV_HOME_DONE: cover property (@(posedge sys_clk) hs_ff == VHM_HS_DONE);
  COV_HOME_FAIL: cover property (@(posedge sys_clk) hs_ff == VHM_HS_FAIL);
  COV_VEL: cover property (@(posedge sys_clk) mode_ff == VHM_MODE_VEL && gen_speed != 0);
endmodule : vhm_ctrl

// ===== sim/vhm_axis_model.sv
`timescale 1ns/10ps
// ****************************************
// axis model: motor shaft, encoder and switches
// ****************************************
module vhm_axis_model
  import vhm_pkg::*;
#(
  parameter int LIM_POS = 1200,
  parameter int REF_BAND = 20,
  parameter int SLIP = 2
)(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic inject_fault,
  input wire logic signed [31:0] speed_command,
  output vhm_axis_s axis,
  output logic signed [15:0] encoder_speed,
  output logic signed [31:0] encoder_position
);
  logic signed [31:0] pos_ff;
  // shaft follows the command with the drive's own scaling
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pos_ff <= '0;
    end else begin
      pos_ff <= pos_ff + (speed_command >>> 4);
    end
  end
  // every switch a method needs is wired; reference cam sits in a band near zero
  always_comb begin
    axis.neg_limit = (pos_ff <= -LIM_POS);
    axis.pos_limit = (pos_ff >= LIM_POS);
    axis.ref_sw = (pos_ff >= -REF_BAND) && (pos_ff <= REF_BAND);
    axis.index_pulse = (pos_ff[7:0] < 8'h04);
    axis.fault = inject_fault;
  end
  // encoder speed reads SLIP below the command so it is told apart from the reference
  assign encoder_speed = speed_command[15:0] - 16'(SLIP);
  assign encoder_position = pos_ff;
endmodule : vhm_axis_model

// ===== sim/tb.sv
`timescale 1ns/10ps
`include "vhm_consts.svh"
module tb
  import vhm_pkg::*;
;
  typedef struct packed {logic [15:0] addr; logic [31:0] exp;} vhm_row_s;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  vhm_reg_req_s reg_req = '0;
  logic [31:0] reg_rdata;
  logic [15:0] process_word_two = '0;
  logic process_word_two_valid = 1'b0;
  logic [15:0] drive_control_word = '0;
  logic [15:0] mode_control_word = '0;
  logic [15:0] drive_status_word;
  logic [15:0] mode_status_word;
  vhm_axis_s axis;
  logic signed [15:0] encoder_speed;
  logic signed [31:0] encoder_position;
  logic signed [31:0] speed_command;
  logic encoder_temp_monitor_en;
  logic rotation_monitor_en;
  logic inject_fault = 1'b0;
  int fail_count = 0;
  int tests_run = 0;
  vhm_row_s rows [8] = '{'{`VHM_OFS_ENC_SEL, 32'h0}, '{`VHM_OFS_MEAS_SPD, 32'h0},
    '{`VHM_OFS_GEN_SPD, 32'h0}, '{`VHM_OFS_CEIL, `VHM_CEIL_RST},
    '{`VHM_OFS_ACCEL, `VHM_ACCEL_RST}, '{`VHM_OFS_HM_DIST, `VHM_HM_DIST_RST},
    '{`VHM_OFS_ACT_POS, 32'h0}, '{16'h1234, 32'h0}};
  logic [2:0] meth [4] = '{3'h1, 3'h0, 3'h3, 3'h2};
  logic [15:0] sel [3] = '{16'h0, 16'h2, 16'h3};

  always #20 sys_clk = ~sys_clk;

  vhm_ctrl vhm_ctrl_inst (.sys_clk(sys_clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .process_word_two(process_word_two),
    .process_word_two_valid(process_word_two_valid),
    .drive_control_word(drive_control_word), .mode_control_word(mode_control_word),
    .drive_status_word(drive_status_word), .mode_status_word(mode_status_word),
    .axis(axis), .encoder_speed(encoder_speed), .encoder_position(encoder_position),
    .speed_command(speed_command), .encoder_temp_monitor_en(encoder_temp_monitor_en),
    .rotation_monitor_en(rotation_monitor_en));
  vhm_axis_model vhm_axis_model_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .inject_fault(inject_fault),
    .speed_command(speed_command), .axis(axis), .encoder_speed(encoder_speed),
    .encoder_position(encoder_position));

  // ****************************************
  // helpers
  // ****************************************
  task automatic summarize();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  task automatic ck(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : ck
  task automatic near(input logic signed [31:0] got, input int exp, input string what);
    tests_run++;
    if (^got === 1'bx || got > exp + 32 || got < exp - 32) begin
      fail_count++;
      $display("ERROR t=%0t %s got %0d near %0d", $time, what, got, exp);
    end
  endtask : near
  task automatic bound_hit(input int i, input int n);
    if (i >= n) begin
      fail_count++;
      $display("ERROR t=%0t wait ran out", $time);
      summarize();
    end
  endtask : bound_hit
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_req <= {a, d, 1'b1};
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_req <= {a, 32'h0, 1'b0};
    tick(1);
    d = reg_rdata;
  endtask : rd
  task automatic go(input logic [1:0] m, input logic idx);
    @(posedge sys_clk);
    mode_control_word <= {13'h0, idx, m};
    drive_control_word <= 16'h0005;
    @(posedge sys_clk);
    drive_control_word <= 16'h0001;
    #1;
  endtask : go
  task automatic wait_hs(input logic [2:0] st, input int n);
    int i;
    for (i = 0; i < n && mode_status_word[4:2] !== st; i++) tick(1);
    bound_hit(i, n);
  endtask : wait_hs
  task automatic wait_spd(input logic [31:0] v, input int n);
    int i;
    for (i = 0; i < n && speed_command !== v; i++) tick(1);
    bound_hit(i, n);
  endtask : wait_spd

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] d;
    logic signed [31:0] s1;
    int k;
    tick(4);
    ck(speed_command, 32'h0, "spd in reset");
    ck(32'(drive_status_word), 32'h0, "dsw in reset");
    @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      rd(rows[i].addr, d);
      ck(d, rows[i].exp, "reg reset");
    end
    wr(`VHM_OFS_GEN_SPD, 32'h5);
    wr(16'h1234, 32'h7);
    rd(`VHM_OFS_GEN_SPD, d);
    ck(d, 32'h0, "ro write");
    rd(16'h1234, d);
    ck(d, 32'h0, "unmapped");
    foreach (sel[i]) begin
      wr(`VHM_OFS_ENC_SEL, 32'(sel[i]));
      rd(`VHM_OFS_ENC_SEL, d);
      ck(d, 32'(sel[i]), "enc sel");
      ck(32'(encoder_temp_monitor_en), 32'(sel[i] != 0), "temp mon");
      ck(32'(rotation_monitor_en), 32'(sel[i] == 3), "rot mon");
    end
    $display("test registers done");
    wr(`VHM_OFS_ENC_SEL, 32'h0);
    wr(`VHM_OFS_ACCEL, 32'd50);
    wr(`VHM_OFS_DECEL, 32'd50);
    wr(`VHM_OFS_CEIL, 32'd1000);
    wr(`VHM_OFS_TGT_VEL, 32'd500);
    drive_control_word <= 16'h0001;
    go(2'd1, 1'b0);
    tick(3);
    s1 = speed_command;
    tick(1);
    ck(speed_command - s1, 32'd50, "ramp step");
    wait_spd(32'd500, 40);
    @(posedge sys_clk);
    process_word_two <= 16'h0bb8;
    process_word_two_valid <= 1'b1;
    @(posedge sys_clk);
    process_word_two_valid <= 1'b0;
    wait_spd(32'd1000, 40);
    tick(40);
    ck(speed_command, 32'd1000, "clamp");
    ck(32'(axis.pos_limit), 32'h1, "past limit");
    rd(`VHM_OFS_GEN_SPD, d);
    ck(d, 32'd1000, "gen spd");
    rd(`VHM_OFS_MEAS_SPD, d);
    ck(d, 32'd1000, "ref as meas");
    wr(`VHM_OFS_ENC_SEL, 32'h2);
    rd(`VHM_OFS_MEAS_SPD, d);
    ck(d, 32'd998, "meas spd");
    wr(`VHM_OFS_ENC_SEL, 32'h0);
    @(posedge sys_clk);
    process_word_two <= 16'hff38;
    process_word_two_valid <= 1'b1;
    @(posedge sys_clk);
    process_word_two_valid <= 1'b0;
    wait_spd(32'hffffff38, 80);
    wr(`VHM_OFS_TGT_VEL, 32'h0);
    wait_spd(32'h0, 40);
    $display("test velocity done");
    wr(`VHM_OFS_HM_OFFSET, 32'd100);
    foreach (meth[i]) begin
      wr(`VHM_OFS_HM_METHOD, 32'(meth[i]));
      go(2'd2, 1'b0);
      wait_hs(VHM_HS_TRAVEL, 3000);
      for (k = 0; k < 100 && mode_status_word[4:2] === VHM_HS_TRAVEL; k++) tick(1);
      ck(32'(k), `VHM_HM_DIST_RST, "travel len");
      wait_hs(VHM_HS_DONE, 50);
      ck(32'(drive_status_word[1]), 32'h1, "ref valid");
      rd(`VHM_OFS_ACT_POS, d);
      near(d, 100, "zero offset");
    end
    wr(`VHM_OFS_ENC_SEL, 32'h2);
    wr(`VHM_OFS_HM_METHOD, 32'h3);
    go(2'd2, 1'b1);
    wait_hs(VHM_HS_INDEX, 500);
    wait_hs(VHM_HS_DONE, 500);
    ck(32'(drive_status_word[1]), 32'h1, "idx ref");
    drive_control_word <= 16'h0000;
    tick(3);
    ck(32'(drive_status_word[1]), 32'h1, "ref kept");
    drive_control_word <= 16'h0001;
    $display("test homing done");
    wr(`VHM_OFS_HM_METHOD, 32'h0);
    go(2'd2, 1'b0);
    tick(5);
    go(2'd1, 1'b0);
    ck(32'(mode_status_word[1:0]), 32'h2, "mode locked");
    ck(32'(mode_status_word[4:2]), 32'(VHM_HS_SEEK), "still seek");
    drive_control_word <= 16'h0003;
    wait_hs(VHM_HS_FAIL, 200);
    ck(32'(drive_status_word[2:1]), 32'h2, "halted");
    drive_control_word <= 16'h0001;
    go(2'd2, 1'b0);
    tick(2);
    @(posedge sys_clk);
    inject_fault <= 1'b1;
    wait_hs(VHM_HS_FAIL, 10);
    ck(32'(drive_status_word[2]), 32'h1, "fault ends homing");
    @(posedge sys_clk);
    inject_fault <= 1'b0;
    $display("test halt done");
    wr(`VHM_OFS_ENC_SEL, 32'h0);
    wr(`VHM_OFS_SET_POS, 32'h00003039);
    drive_control_word <= 16'h0009;
    @(posedge sys_clk);
    drive_control_word <= 16'h0001;
    tick(2);
    rd(`VHM_OFS_ACT_POS, d);
    ck(d, 32'h00003039, "set pos");
    $display("test set position done");
    summarize();
  end
endmodule : tb
